// *** verilog/slave_output_channel.sv ***
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - parity stored with every buffer write
// - parity regenerated and compared on buffer read
// - mismatch sets buffer parity error bit 8
// - parity error never stops the transfer
// - parity error cleared by clear bit 3
// - secded check before writing the buffer
// - interrupt on mask bits 6, 5, 2, 1, 0
// - host sends address/length, device captures both words
// - capture layout follows channel rate
// - capture done sets flag bit 5
// - flag 5 with mask 5 raises interrupt
// - reading word0 reserves first block for mover
// - disable_check_bits forces check bits zero
// - error bit 1 mirrors disable_check_bits
// - clear bits 2,3,4 reset address, data, ram
// - errors reported through error and flag words
// - data ready shown until host transmit strobe
// - length counts down, final word flagged
module slave_output_channel
    import slave_out_pkg::*;
(
    input  wire logic                mclk_i,
    input  wire logic                nrst_i,
    input  wire bus_req_t            bus_i,
    output logic      [DATA_W-1:0]   rdata_o,
    output logic                     irq_o,
    input  wire logic [ALINE_W-1:0]  addr_lines_i,
    input  wire logic                addr_strobe_i,
    input  wire logic                addr_par_i,
    input  wire logic                disable_check_bits_i,
    input  wire logic                xmit_i,
    output chan_out_t                chan_o,
    input  wire logic                bm_wr_i,
    input  wire word_t               bm_word_i,
    output logic                     bm_ready_o,
    output logic                     bm_reserved_o
);
    typedef struct packed {
        tx_state_t          st;
        logic [DATA_W-1:0]  rdata;
        logic               irq;
        logic               chan_err;
        logic               sbe;
        logic               mbe;
        logic               adone;
        logic               ddone;
        logic [FLAG_W-1:0]  imask;
        logic               dis;
        logic               blk;
        logic               par;
        logic               apar;
        logic               ardy;
        logic [ALINE_W-1:0] word0;
        logic [ALINE_W-1:0] word1;
        logic [1:0]         piece;
        logic [LEN_W-1:0]   len;
        logic               rate_hi;
        logic               reserved;
        logic               bm_ready;
        logic [PTR_W-1:0]   wr_ptr;
        logic [PTR_W-1:0]   rd_ptr;
        chan_out_t          out;
    } core_t;

    localparam core_t CORE_RST = '{st: ST_IDLE, default: '0};

    core_t r;
    core_t n;

    logic              reg_wr;
    logic              reg_rd;
    logic              buf_wr;
    logic              bm_take;
    logic              mem_we;
    logic              mem_re;
    logic [BUS_W-1:0]  mem_rdata;
    logic [DATA_W-1:0] in_data;
    logic [CHK_W-1:0]  in_chk;
    logic [DATA_W-1:0] fixed_data;
    logic              in_sbe;
    logic              in_mbe;
    logic [CHK_W-1:0]  out_chk;
    logic [BYTE_N-1:0] wpar;
    logic [BYTE_N-1:0] rpar;
    logic              par_bad;
    logic [PTR_W-1:0]  fill;
    logic [4:0]        blk_left;
    logic [PTR_W-1:0]  need;
    logic              can_read;
    logic              clr_addr;
    logic              clr_data;
    logic              clr_ram;
    logic              last_piece;
    logic [FLAG_W-1:0] iflag_vec;
    logic [FLAG_W-1:0] err_vec;

    // software port decode; bit 7 of the address opens the buffer window
    assign reg_wr   = bus_i.wr && !bus_i.addr[BUF_SEL_BIT];
    assign reg_rd   = bus_i.rd && !bus_i.addr[BUF_SEL_BIT];
    assign buf_wr   = bus_i.wr && bus_i.addr[BUF_SEL_BIT];
    assign clr_addr = reg_wr && (bus_i.addr == OFF_CLEAR) && bus_i.wdata[CLR_ADDR];
    assign clr_data = reg_wr && (bus_i.addr == OFF_CLEAR) && bus_i.wdata[CLR_DATA];
    assign clr_ram  = reg_wr && (bus_i.addr == OFF_CLEAR) && bus_i.wdata[CLR_RAM];

    // processor wins the single write port; the mover must not write beside it
    assign bm_take = bm_wr_i && r.bm_ready;
    assign mem_we  = buf_wr || bm_take;
    assign in_data = buf_wr ? bus_i.wdata[DATA_W-1:0] : bm_word_i.data;
    assign in_chk  = buf_wr ? bus_i.wdata[BUS_W-1:DATA_W] : bm_word_i.chk;

    // incoming word checked and repaired before it lands in the buffer
    secded_word u_in_check (
        .data_i (in_data),
        .chk_i  (in_chk),
        .data_o (fixed_data),
        .chk_o  (),
        .sbe_o  (in_sbe),
        .mbe_o  (in_mbe)
    );

    // fresh check bits for the word leaving on the channel
    secded_word u_out_gen (
        .data_i (mem_rdata[DATA_W-1:0]),
        .chk_i  ('0),
        .data_o (),
        .chk_o  (out_chk),
        .sbe_o  (),
        .mbe_o  ()
    );

    // byte parity on the write side and again on the read side
    for (genvar b = 0; b < BYTE_N; b++) begin : g_par
        assign wpar[b] = ^fixed_data[b*8 +: 8];
        assign rpar[b] = ^mem_rdata[b*8 +: 8];
    end
    assign par_bad = rpar != mem_rdata[BUS_W-1:DATA_W];

    out_buf_ram #(
        .W  (BUS_W),
        .AW (BUF_AW)
    ) u_ram (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .we_i    (mem_we),
        .waddr_i (r.wr_ptr[BUF_AW-1:0]),
        .wdata_i ({wpar, fixed_data}),
        .re_i    (mem_re),
        .raddr_i (r.rd_ptr[BUF_AW-1:0]),
        .rdata_o (mem_rdata)
    );

    // a 16-word block is read once full or once it holds the last word
    assign fill     = r.wr_ptr - r.rd_ptr;
    assign blk_left = RD_BLK_WORDS - {1'b0, r.rd_ptr[3:0]};
    assign need     = (r.len < {13'h0, blk_left}) ? r.len[PTR_W-1:0] : {3'h0, blk_left};
    assign can_read = (r.len != '0) && (fill >= need);
    assign mem_re   = (r.st == ST_IDLE) && can_read && !clr_data && !clr_ram;

    assign last_piece = r.rate_hi ? (r.piece == PIECE_LAST_HI) : (r.piece == PIECE_LAST_LO);

    always_comb begin
        n       = r;
        n.rdata = '0;

        // clears first, so an address, parity or handshake error in the same cycle still sets its flag
        if (clr_addr) begin
            n.piece    = '0;
            n.adone    = 1'b0;
            n.apar     = 1'b0;
            n.ardy     = 1'b0;
            n.reserved = 1'b0;
        end
        if (clr_data) begin
            n.par   = 1'b0;
            n.blk   = 1'b0;
            n.ddone = 1'b0;
            n.st    = ST_IDLE;
            n.out   = '0;
        end
        if (clr_ram) begin
            n.wr_ptr = '0;
            n.rd_ptr = '0;
        end

        // address/length capture from the host lines
        if (addr_strobe_i) begin
            if (r.adone) begin
                n.ardy = 1'b1;
            end else begin
                if (^{addr_lines_i, addr_par_i}) n.apar = 1'b1;
                if (r.rate_hi) begin
                    if (r.piece[0]) n.word1 = addr_lines_i;
                    else            n.word0 = addr_lines_i;
                end else begin
                    case (r.piece)
                        2'h0:    n.word0[HALF_W-1:0]       = addr_lines_i[HALF_W-1:0];
                        2'h1:    n.word0[ALINE_W-1:HALF_W] = addr_lines_i[HALF_W-1:0];
                        2'h2:    n.word1[HALF_W-1:0]       = addr_lines_i[HALF_W-1:0];
                        default: n.word1[ALINE_W-1:HALF_W] = addr_lines_i[HALF_W-1:0];
                    endcase
                end
                n.piece = r.piece + 2'h1;
                if (last_piece) begin
                    n.piece = '0;
                    n.adone = 1'b1;
                end
            end
        end

        // incoming word accepted into the buffer
        if (mem_we && !clr_ram) begin
            n.wr_ptr = r.wr_ptr + 8'h01;
            if (in_sbe) n.sbe = 1'b1;
            if (in_mbe) n.mbe = 1'b1;
        end

        // word pump towards the channel
        case (r.st)
            ST_IDLE: begin
                if (mem_re) begin
                    n.rd_ptr = r.rd_ptr + 8'h01;
                    n.st     = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (!clr_data) begin
                    n.out.data    = mem_rdata[DATA_W-1:0];
                    n.out.chk     = disable_check_bits_i ? '0 : out_chk;
                    n.out.ready   = 1'b1;
                    n.out.final_w = (r.len == LEN_LAST);
                    n.st          = ST_SEND;
                end
                if (par_bad) n.par = 1'b1;
            end
            ST_SEND: begin
                if (xmit_i && !clr_data) begin
                    n.out.ready   = 1'b0;
                    n.out.final_w = 1'b0;
                    n.len         = r.len - LEN_LAST;
                    if (r.len == LEN_LAST) n.ddone = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // transmit strobe with no word on the lines is a handshake error
        if (xmit_i && (r.st != ST_SEND)) n.blk = 1'b1;

        n.dis = disable_check_bits_i;

        // register writes
        if (reg_wr) begin
            case (bus_i.addr)
                OFF_IMASK:  n.imask          = bus_i.wdata[FLAG_W-1:0];
                OFF_LEN_LO: n.len[LEN_LO_W-1:0] = bus_i.wdata[LEN_LO_W-1:0];
                OFF_LEN_HI: n.len[LEN_W-1:LEN_LO_W] = bus_i.wdata[LEN_HI_W-1:0];
                OFF_ACFG:   n.rate_hi        = bus_i.wdata[CFG_RATE_HI];
                OFF_SYNCLR: begin
                    n.sbe = mem_we && in_sbe;
                    n.mbe = mem_we && in_mbe;
                end
                default: ;
            endcase
        end

        // summary channel error: set on any error-bit rise or any disable-bit change, cleared by data-control clear when quiet
        if ((n.blk && !r.blk) || (n.par && !r.par) || (n.apar && !r.apar)
                || (n.ardy && !r.ardy) || (n.dis != r.dis)) begin
            n.chan_err = 1'b1;
        end else if (clr_data && !(n.blk || n.par || n.apar || n.ardy)) begin
            n.chan_err = 1'b0;
        end

        iflag_vec              = '0;
        iflag_vec[IF_CHAN_ERR] = n.chan_err;
        iflag_vec[IF_SBE]      = n.sbe;
        iflag_vec[IF_MBE]      = n.mbe;
        iflag_vec[IF_ADONE]    = n.adone;
        iflag_vec[IF_DDONE]    = n.ddone;
        err_vec                = '0;
        err_vec[ER_DIS]        = r.dis;
        err_vec[ER_BLK]        = r.blk;
        err_vec[ER_PAR]        = r.par;
        err_vec[ER_APAR]       = r.apar;
        err_vec[ER_ARDY]       = r.ardy;

        // one interrupt line gated by the mask word
        n.irq = |(iflag_vec & n.imask);

        // register reads; data stands only in the following cycle
        if (reg_rd) begin
            case (bus_i.addr)
                OFF_IFLAG:  n.rdata = {48'h0, iflag_vec};
                OFF_IMASK:  n.rdata = {48'h0, r.imask};
                OFF_ERR:    n.rdata = {48'h0, err_vec};
                OFF_ADDR0: begin
                    n.rdata    = {32'h0, r.word0};
                    n.reserved = 1'b1;
                end
                OFF_ADDR1:  n.rdata = {32'h0, r.word1};
                OFF_LEN_LO: n.rdata = {48'h0, r.len[LEN_LO_W-1:0]};
                OFF_ACFG:   n.rdata = {63'h0, r.rate_hi};
                default:    n.rdata = '0;
            endcase
        end

        // mover may write once the first block is reserved and room remains
        n.bm_ready = n.reserved && (fill < BM_FILL_MAX);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    assign rdata_o       = r.rdata;
    assign irq_o         = r.irq;
    assign chan_o        = r.out;
    assign bm_ready_o    = r.bm_ready;
    assign bm_reserved_o = r.reserved;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_load;
        r.st == ST_LOAD && !clr_data;
    endsequence

    sequence s_word_taken;
        r.st == ST_SEND && xmit_i && !clr_data;
    endsequence

    a_parity_sets: assert property (s_load ##0 par_bad |=> r.par)
        else $error("parity mismatch did not set error bit");
    a_parity_no_halt: assert property (s_load |=> chan_o.ready ##0 r.st == ST_SEND)
        else $error("word not presented after buffer read");
    a_parity_sticky: assert property (r.par && !clr_data |=> r.par)
        else $error("parity error dropped without clear");
    a_parity_clear: assert property (clr_data && r.st != ST_LOAD |=> !r.par)
        else $error("parity error survived data-control clear");
    a_chk_disabled: assert property (s_load ##0 disable_check_bits_i |=> chan_o.chk == 8'h00)
        else $error("check bits not zero while disabled");
    a_dis_mirror: assert property (disable_check_bits_i != $past(disable_check_bits_i)
            |=> r.dis == $past(disable_check_bits_i) && r.chan_err)
        else $error("disable bit or channel error not following host");
    a_addr_irq: assert property (r.adone && r.imask[IF_ADONE] |-> irq_o)
        else $error("address complete did not interrupt");
    a_final_word: assert property (chan_o.ready && chan_o.final_w |-> r.len == LEN_LAST)
        else $error("final word flagged with length not one");
    a_done_after_last: assert property (s_word_taken ##0 r.len == LEN_LAST
            |=> r.ddone && !chan_o.ready ##1 r.len == 18'h0 || reg_wr)
        else $error("last word did not complete transfer");
    a_reserve_read: assert property (reg_rd && bus_i.addr == OFF_ADDR0 |=> bm_reserved_o)
        else $error("word0 read did not reserve block");
    a_ready_held: assert property (chan_o.ready && !xmit_i && !clr_data |=> chan_o.ready)
        else $error("data ready dropped before transmit strobe");
endmodule
`default_nettype wire

// *** verilog/slave_out_pkg.sv ***
package slave_out_pkg;

    // word and buffer geometry
    localparam int DATA_W    = 64;
    localparam int CHK_W     = 8;
    localparam int HAM_W     = 7;
    localparam int BYTE_N    = 8;
    localparam int BUF_AW    = 7;
    localparam int PTR_W     = 8;
    localparam int BUS_AW    = 8;
    localparam int BUS_W     = 72;
    localparam int LEN_W     = 18;
    localparam int LEN_LO_W  = 16;
    localparam int LEN_HI_W  = 2;
    localparam int ALINE_W   = 32;
    localparam int HALF_W    = 16;
    localparam int FLAG_W    = 16;

    // buffer handshake figures
    localparam logic [4:0]  RD_BLK_WORDS = 5'h10;
    localparam logic [7:0]  BM_FILL_MAX  = 8'h7e;
    localparam logic [17:0] LEN_LAST     = 18'h00001;

    // address/length capture piece counts, last piece index
    localparam logic [1:0] PIECE_LAST_LO = 2'h3;
    localparam logic [1:0] PIECE_LAST_HI = 2'h1;

    // register indices on the software port; bit 7 selects the buffer window
    localparam int          BUF_SEL_BIT = 7;
    localparam logic [7:0]  OFF_IFLAG   = 8'h00;
    localparam logic [7:0]  OFF_IMASK   = 8'h01;
    localparam logic [7:0]  OFF_ERR     = 8'h02;
    localparam logic [7:0]  OFF_CLEAR   = 8'h03;
    localparam logic [7:0]  OFF_ADDR0   = 8'h04;
    localparam logic [7:0]  OFF_ADDR1   = 8'h05;
    localparam logic [7:0]  OFF_LEN_LO  = 8'h06;
    localparam logic [7:0]  OFF_LEN_HI  = 8'h07;
    localparam logic [7:0]  OFF_ACFG    = 8'h08;
    localparam logic [7:0]  OFF_SYNCLR  = 8'h09;

    // interrupt_flag_word bits
    localparam int IF_CHAN_ERR = 0;
    localparam int IF_SBE      = 1;
    localparam int IF_MBE      = 2;
    localparam int IF_ADONE    = 5;
    localparam int IF_DDONE    = 6;

    // error register bits
    localparam int ER_DIS  = 1;
    localparam int ER_BLK  = 2;
    localparam int ER_PAR  = 8;
    localparam int ER_APAR = 9;
    localparam int ER_ARDY = 12;

    // io_clear_control bits and addr_channel_config bit
    localparam int CLR_ADDR    = 2;
    localparam int CLR_DATA    = 3;
    localparam int CLR_RAM     = 4;
    localparam int CFG_RATE_HI = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_LOAD = 3'h2,
        ST_SEND = 3'h4
    } tx_state_t;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [BUS_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHK_W-1:0]  chk;
    } word_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHK_W-1:0]  chk;
        logic              ready;
        logic              final_w;
    } chan_out_t;

endpackage

// *** verilog/secded_word.sv ***
`timescale 1ns/10ps
`default_nettype none
module secded_word
    import slave_out_pkg::*;
(
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic [CHK_W-1:0]  chk_i,
    output logic      [DATA_W-1:0] data_o,
    output logic      [CHK_W-1:0]  chk_o,
    output logic                   sbe_o,
    output logic                   mbe_o
);
    // hamming position of data bit j: j-th index that is not a power of two
    function automatic logic [HAM_W-1:0] pos_of(input int j);
        int c;
        logic [HAM_W-1:0] res;
        c   = 0;
        res = '0;
        for (int k = 3; k < 128; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (c == j) res = HAM_W'(k);
                c++;
            end
        end
        return res;
    endfunction

    logic [HAM_W-1:0]  syn;
    logic [DATA_W-1:0] fix;
    logic              odd;

    // one check bit per hamming column
    for (genvar i = 0; i < HAM_W; i++) begin : g_chk
        logic [DATA_W-1:0] sel;
        for (genvar j = 0; j < DATA_W; j++) begin : g_sel
            localparam logic [HAM_W-1:0] POS = pos_of(j);
            assign sel[j] = data_i[j] & POS[i];
        end
        assign chk_o[i] = ^sel;
    end
    assign chk_o[CHK_W-1] = ^{data_i, chk_o[HAM_W-1:0]};

    // odd overall parity means one flip, even with nonzero syndrome means two
    assign syn   = chk_o[HAM_W-1:0] ^ chk_i[HAM_W-1:0];
    assign odd   = ^{data_i, chk_i};
    assign sbe_o = odd;
    assign mbe_o = !odd && (syn != '0);

    // flip the one data bit the syndrome points at
    for (genvar j = 0; j < DATA_W; j++) begin : g_fix
        assign fix[j] = odd && (syn == pos_of(j));
    end
    assign data_o = data_i ^ fix;
endmodule
`default_nettype wire

// *** verilog/out_buf_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module out_buf_ram #(
    parameter int W  = 72,
    parameter int AW = 7
) (
    input  wire logic          mclk_i,
    input  wire logic          nrst_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic          re_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    // array has no reset; only the read register does
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// *** dv/host_chan_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_chan_model
    import slave_out_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire chan_out_t     chan_i,
    output logic [ALINE_W-1:0] lines_o,
    output logic               strobe_o,
    output logic               par_o,
    output logic               xmit_o
);
    int                lat = 0;
    int                words_n = 0;
    logic              fin_seen = 1'b0;
    logic [DATA_W-1:0] data_seen = '0;
    logic [CHK_W-1:0]  chk_seen  = '0;

    // quiet lines at time zero
    initial begin
        lines_o  = '0;
        strobe_o = 1'b0;
        par_o    = 1'b0;
        xmit_o   = 1'b0;
    end

    // one address/length piece; bad breaks the even parity
    task automatic send_piece(input logic [ALINE_W-1:0] v, input logic bad);
        @(posedge mclk_i);
        lines_o  <= v;
        par_o    <= (^v) ^ bad;
        strobe_o <= 1'b1;
        @(posedge mclk_i);
        strobe_o <= 1'b0;
        lines_o  <= ~v; // released lines must not keep the value
    endtask

    // takes a shown word, stalls lat cycles, then pulses transmit-data
    always @(posedge mclk_i) begin
        if (chan_i.ready === 1'b1 && xmit_o === 1'b0) begin
            data_seen <= chan_i.data;
            chk_seen  <= chan_i.chk;
            fin_seen  <= chan_i.final_w;
            repeat (lat) @(posedge mclk_i);
            xmit_o <= 1'b1;
            @(posedge mclk_i);
            xmit_o <= 1'b0;
            words_n++;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_slave_output_channel.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_slave_output_channel
    import slave_out_pkg::*;
();
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    bus_req_t          bus = '0;
    logic              dis = 1'b0;
    logic              bm_wr = 1'b0;
    word_t             bm_word = '0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] d;
    logic              irq;
    logic              bm_ready;
    logic              bm_reserved;
    chan_out_t         chan;
    logic [ALINE_W-1:0] lines;
    logic              strobe;
    logic              par;
    logic              xmit;
    int                error_cnt = 0;
    int                num_checks = 0;

    // 50 MHz clock
    always #10 mclk = ~mclk;

    slave_output_channel DUT (.mclk_i(mclk), .nrst_i(rst_n), .bus_i(bus), .rdata_o(rdata),
        .irq_o(irq), .addr_lines_i(lines), .addr_strobe_i(strobe), .addr_par_i(par),
        .disable_check_bits_i(dis), .xmit_i(xmit), .chan_o(chan), .bm_wr_i(bm_wr),
        .bm_word_i(bm_word), .bm_ready_o(bm_ready), .bm_reserved_o(bm_reserved));

    host_chan_model host (.mclk_i(mclk), .chan_i(chan), .lines_o(lines), .strobe_o(strobe),
        .par_o(par), .xmit_o(xmit));

    // register port cycles; read data sampled in its single valid cycle
    task automatic wr(input logic [7:0] a, input logic [BUS_W-1:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // fast-rate capture, completion flag, reservation, refused extra piece
    task automatic t_addr_hi();
        wr(OFF_ACFG, 72'h1);
        wr(OFF_IMASK, 72'h66);
        host.send_piece(32'h1234_5678, 1'b0);
        // step off the edge so the flag update has landed
        #1;
        `CHK(irq, 1'b0)
        host.send_piece(32'h9abc_def0, 1'b0);
        rd(OFF_IFLAG);
        `CHK(d[IF_ADONE], 1'b1)
        `CHK(irq, 1'b1)
        rd(OFF_ADDR1);
        `CHK({d, bm_reserved}, {64'h9abc_def0, 1'b0})
        rd(OFF_ADDR0);
        `CHK({d, bm_reserved}, {64'h1234_5678, 1'b1})
        host.send_piece(32'h0, 1'b0);
        rd(OFF_ERR);
        `CHK(d[ER_ARDY], 1'b1)
    endtask

    // two words with a slow host; the last one carries a corrected bit
    task automatic t_data();
        int i;
        @(posedge mclk);
        dis <= 1'b1;
        wr(OFF_LEN_LO, 72'h2);
        wr(OFF_LEN_HI, 72'h0);
        wr(8'h80, 72'h0);
        for (i = 0; i < 50 && bm_ready !== 1'b1; i++) @(posedge mclk);
        `CHK(bm_ready, 1'b1)
        // next sequential word as a stride-one mover sends it; data bit 4 flipped
        bm_wr   <= 1'b1;
        bm_word <= '{data: 64'h11, chk: 8'h83};
        @(posedge mclk);
        bm_wr <= 1'b0;
        host.lat = 3;
        for (i = 0; i < 300 && host.words_n < 2; i++) @(posedge mclk);
        `CHK(host.words_n, 2)
        `CHK({host.fin_seen, host.data_seen}, {1'b1, 64'h1})
        `CHK(host.chk_seen, 8'h00)
        rd(OFF_IFLAG);
        `CHK({d[IF_DDONE], d[IF_SBE], d[IF_CHAN_ERR]}, 3'h7)
        rd(OFF_ERR);
        `CHK(d[ER_DIS], 1'b1)
        @(posedge mclk);
        dis <= 1'b0;
        rd(OFF_ERR);
        `CHK(d[ER_DIS], 1'b0)
    endtask

    // clear bits leave the syndrome flags alone until their own clear
    task automatic t_clear();
        wr(OFF_CLEAR, 72'h1c);
        rd(OFF_IFLAG);
        `CHK({d[IF_ADONE], d[IF_DDONE], d[IF_SBE], bm_reserved}, 4'h2)
        rd(OFF_ERR);
        `CHK(d[ER_ARDY], 1'b0)
        wr(8'h83, 72'h3);
        rd(OFF_IFLAG);
        `CHK({d[IF_MBE], d[IF_SBE]}, 2'h3)
        wr(OFF_SYNCLR, 72'h0);
        wr(OFF_CLEAR, 72'h10);
        rd(OFF_IFLAG);
        `CHK({d[IF_MBE], d[IF_SBE]}, 2'h0)
    endtask

    // slow-rate capture in four halves, one with bad parity, then masking
    task automatic t_low();
        wr(OFF_ACFG, 72'h0);
        host.send_piece(32'hffff_1111, 1'b0);
        host.send_piece(32'h0000_2222, 1'b1);
        host.send_piece(32'h0000_3333, 1'b0);
        host.send_piece(32'h0000_4444, 1'b0);
        rd(OFF_ADDR1);
        `CHK(d, 64'h4444_3333)
        rd(OFF_ERR);
        `CHK(d[ER_APAR], 1'b1)
        wr(OFF_IMASK, 72'h0);
        rd(OFF_ADDR0);
        `CHK({d, irq}, {64'h2222_1111, 1'b0})
        wr(OFF_IMASK, 72'h20);
        rd(OFF_IFLAG);
        `CHK(irq, 1'b1)
    endtask

    // counts, verdict, stop
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_addr_hi();
        t_data();
        t_clear();
        t_low();
        end_of_test();
    end

    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
